//--- inc/sfpe_defines.vh
`ifndef SFPE_DEFINES_VH
`define SFPE_DEFINES_VH
// ************************************************************
// byte link constants
// ************************************************************
`define SFPE_BYTE_W        8
`define SFPE_BIT_CNT_W     3
`define SFPE_LAST_BIT      3'h7
`define SFPE_ID_LEN        3'h7
// edges the pin synchroniser needs after release before entry is judged
`define SFPE_SETTLE_CNT    2'h2
// ************************************************************
// command bytes passed to the id gate
// ************************************************************
`define SFPE_CMD_ID_CHECK  8'hF5
`define SFPE_CMD_STATUS    8'h70
`define SFPE_CMD_VERSION   8'hFB
// ************************************************************
// states of the link sequencer
// ************************************************************
`define SFPE_ST_RESET      3'h0
`define SFPE_ST_NORMAL     3'h1
`define SFPE_ST_IDLE       3'h2
`define SFPE_ST_RX         3'h3
`define SFPE_ST_BUSY       3'h4
`define SFPE_ST_ASYNC      3'h5
// ************************************************************
// async bit time less one, in reference clocks, chosen for the bench
// ************************************************************
`define SFPE_ASYNC_DIV     16'h0010
`endif

//--- rtl/sfpe_sync2.v
`timescale 1ns/10ps
`default_nettype none
module sfpe_sync2 #(
   parameter W = 1
) (
   input  wire         clk_i,
   input  wire         reset_n_i,
   input  wire [W-1:0] d_i,
   output wire [W-1:0] q_o
);
   reg [W-1:0] meta_reg;
   reg [W-1:0] sync_reg;
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         meta_reg <= {W{1'b1}};
         sync_reg <= {W{1'b1}};
      end else begin
         meta_reg <= d_i;
         sync_reg <= meta_reg;
      end
   end
   assign q_o = sync_reg;
endmodule // sfpe_sync2
`default_nettype wire

//--- rtl/sfpe_entry.v
// Notes on behaviour
// R1: programmer gives twenty oscillator clocks during reset before release.
// R2: clock pin high at power-on; afterwards it is the transfer clock.
// R3: busy/mode pin sampled at release: high sub-mode 1, low sub-mode 2.
// R4: busy/mode pin input during reset, output after programming mode entry; the code drives it in sub-mode 1 only.
// R5: programming entry needs clock pin high and entry pin at programming level.
// R6: commands, addresses and data move as eight-bit units.
// R7: programmer sources the sub-mode 1 transfer clock; device never drives it.
// R8: sub-mode 1 busy low when ready, high once reception starts.
// R9: sub-mode 2 uses only receive and transmit lines.
// R10: only user flash may be rewritten; boot area program/erase refused.
// R11: device holds a seven-byte identification code.
// R12: with flash holding data, commands rejected until the id matches; the code still accepts id check, status and version.
// R13: each byte travels least significant bit first.
// R14: sub-mode 1 receive bits sampled on transfer clock rising edge.
// R15: sub-mode 1 transmit bits shifted on transfer clock falling edge.
// R16: programmer waits for busy low; device holds busy during work.
// R17: chosen sub-mode stays latched until the next reset.
`timescale 1ns/10ps
`default_nettype none
`include "sfpe_defines.vh"
module sfpe_entry #(
   parameter [55:0] ID_CODE = 56'h0123_4567_89AB_CD, // arbitrary value
   parameter        BW      = 8
) (
   input  wire          REF_CLK_I,
   input  wire          RESET_N_I,
   input  wire          MODE_ENTRY_PIN_I,
   input  wire          SERIAL_CLOCK_ENTRY_PIN_I,
   input  wire          BUSY_MODE_SELECT_PIN_I,
   input  wire          SERIAL_RECEIVE_LINE_I,
   input  wire          FLASH_BLANK_I,
   input  wire          WORK_DONE_I,
   input  wire          TX_LOAD_I,
   input  wire [BW-1:0] TX_BYTE_I,
   input  wire          BOOT_AREA_ADDR_I,
   input  wire          PROG_ERASE_REQ_I,
   output reg           BUSY_MODE_SELECT_PIN_O,
   output reg           BUSY_MODE_SELECT_PIN_OE_N_O,
   output reg           SERIAL_TRANSMIT_LINE_O,
   output reg           PROG_MODE_O,
   output reg           SUB_MODE1_O,
   output reg  [BW-1:0] RX_BYTE_O,
   output reg           RX_VALID_O,
   output reg           CMD_ACCEPT_O,
   output reg           CMD_REJECT_O,
   output reg           ID_OK_O,
   output reg           PROG_ERASE_GRANT_O
);
   // ************************************************************
   // pin synchronisers
   // ************************************************************
   wire [3:0] pins_s;
   sfpe_sync2 #(.W(4)) u_sync (
      .clk_i     (REF_CLK_I),
      .reset_n_i (RESET_N_I),
      .d_i       ({MODE_ENTRY_PIN_I, SERIAL_CLOCK_ENTRY_PIN_I,
                   BUSY_MODE_SELECT_PIN_I, SERIAL_RECEIVE_LINE_I}),
      .q_o       (pins_s)
   );
   wire entry_s = pins_s[3];
   wire sclk_s  = pins_s[2];
   wire bmode_s = pins_s[1];
   wire rxd_s   = pins_s[0];

   reg         sclk_d_reg;
   wire        sclk_rise = sclk_s & ~sclk_d_reg;  // [R14]
   wire        sclk_fall = ~sclk_s & sclk_d_reg;  // [R15]

   // ************************************************************
   // state and datapath registers
   // ************************************************************
   reg [2:0]    state_reg;
   reg [2:0]    state_next;
   reg [1:0]    settle_reg;
   reg [2:0]    bit_reg;
   reg [BW-1:0] shift_reg;
   reg [BW-1:0] tx_reg;
   reg [2:0]    tx_bit_reg;
   reg          tx_act_reg;
   reg [15:0]   div_reg;
   reg          arx_act_reg;
   reg          astart_reg;
   reg          rxd_d_reg;
   reg          cmd_wait_reg;
   reg          id_run_reg;
   reg [2:0]    id_idx_reg;
   reg          id_bad_reg;
   reg          byte_done;
   reg [BW-1:0] byte_val;

   // sub-mode 1: bit sampled on rising transfer clock, lsb first
   always @* begin
      state_next = state_reg;
      case (state_reg)
         `SFPE_ST_RESET: begin
            // synchroniser still shows its reset level until settled
            if (settle_reg != `SFPE_SETTLE_CNT) begin
               state_next = `SFPE_ST_RESET;
            end else if (entry_s && sclk_s) begin           // [R5] [R2]
               state_next = bmode_s ? `SFPE_ST_IDLE
                                    : `SFPE_ST_ASYNC;       // [R3]
            end else begin
               state_next = `SFPE_ST_NORMAL;
            end
         end
         `SFPE_ST_NORMAL: state_next = `SFPE_ST_NORMAL;
         `SFPE_ST_IDLE: begin
            if (sclk_rise)
               state_next = `SFPE_ST_RX;                    // [R8]
         end
         `SFPE_ST_RX: begin
            if (sclk_rise && bit_reg == `SFPE_LAST_BIT)
               state_next = `SFPE_ST_BUSY;
         end
         `SFPE_ST_BUSY: begin
            if (WORK_DONE_I && !tx_act_reg)
               state_next = `SFPE_ST_IDLE;                  // [R16]
         end
         `SFPE_ST_ASYNC: state_next = `SFPE_ST_ASYNC;
         default: state_next = `SFPE_ST_RESET;
      endcase
   end

   // ************************************************************
   // byte assembly for both sub-modes
   // ************************************************************
   always @* begin
      byte_done = 1'b0;
      byte_val  = {rxd_s, shift_reg[BW-1:1]};               // [R13]
      if (state_reg == `SFPE_ST_IDLE || state_reg == `SFPE_ST_RX) begin
         byte_done = sclk_rise && (state_reg == `SFPE_ST_RX)
                     && bit_reg == `SFPE_LAST_BIT;          // [R6]
      end else if (state_reg == `SFPE_ST_ASYNC) begin
         byte_done = arx_act_reg && div_reg == 16'h0000
                     && bit_reg == `SFPE_LAST_BIT;          // [R9]
      end
   end

   always @(posedge REF_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         state_reg   <= `SFPE_ST_RESET;
         sclk_d_reg  <= 1'b1;
         bit_reg     <= 3'h0;
         shift_reg   <= 8'h00;
         div_reg     <= 16'h0000;
         arx_act_reg <= 1'b0;
         astart_reg  <= 1'b0;
         rxd_d_reg   <= 1'b1;
         settle_reg  <= 2'h0;
      end else begin
         state_reg  <= state_next;
         if (state_reg == `SFPE_ST_RESET
             && settle_reg != `SFPE_SETTLE_CNT)
            settle_reg <= settle_reg + 2'h1;
         sclk_d_reg <= sclk_s;
         rxd_d_reg  <= rxd_s;
         if (state_reg == `SFPE_ST_IDLE && sclk_rise) begin
            shift_reg <= byte_val;                           // [R14]
            bit_reg   <= 3'h1;
         end else if (state_reg == `SFPE_ST_RX && sclk_rise) begin
            shift_reg <= byte_val;
            bit_reg   <= bit_reg + 3'h1;
         end else if (state_reg == `SFPE_ST_ASYNC) begin
            // sub-mode 2: start bit, then 8 data bits at mid-bit
            if (!arx_act_reg && !astart_reg && rxd_d_reg && !rxd_s) begin
               astart_reg <= 1'b1;
               div_reg    <= `SFPE_ASYNC_DIV + (`SFPE_ASYNC_DIV >> 1);
               bit_reg    <= 3'h0;
            end else if (astart_reg) begin
               astart_reg  <= 1'b0;
               arx_act_reg <= 1'b1;
            end else if (arx_act_reg) begin
               if (div_reg == 16'h0000) begin
                  shift_reg <= byte_val;                     // [R13]
                  div_reg   <= `SFPE_ASYNC_DIV;
                  bit_reg   <= bit_reg + 3'h1;
                  if (bit_reg == `SFPE_LAST_BIT)
                     arx_act_reg <= 1'b0;
               end else begin
                  div_reg <= div_reg - 16'h0001;
               end
            end
         end
      end
   end

   // ************************************************************
   // transmit: sub-mode 1 on falling clock, sub-mode 2 per bit time
   // ************************************************************
   reg [15:0] tdiv_reg;
   reg        tx_stop_reg;
   always @(posedge REF_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         tx_reg                 <= 8'h00;
         tx_bit_reg             <= 3'h0;
         tx_act_reg             <= 1'b0;
         tdiv_reg               <= 16'h0000;
         tx_stop_reg            <= 1'b0;
         SERIAL_TRANSMIT_LINE_O <= 1'b1;
      end else begin
         if (TX_LOAD_I && !tx_act_reg && PROG_MODE_O) begin
            tx_reg     <= TX_BYTE_I;
            tx_bit_reg <= 3'h0;
            tx_act_reg <= 1'b1;
            tdiv_reg   <= `SFPE_ASYNC_DIV;
            // async needs a start bit; sync puts bit 0 out at once
            SERIAL_TRANSMIT_LINE_O <= SUB_MODE1_O ? TX_BYTE_I[0] : 1'b0;
         end else if (tx_act_reg && SUB_MODE1_O) begin
            // each fall presents bit tx_bit_reg, the first fall bit 0 again; the last one stands after
            if (sclk_fall) begin                             // [R15]
               SERIAL_TRANSMIT_LINE_O <= tx_reg[tx_bit_reg];
               tx_bit_reg             <= tx_bit_reg + 3'h1;
               if (tx_bit_reg == `SFPE_LAST_BIT)
                  tx_act_reg <= 1'b0;
            end
         end else if (tx_act_reg) begin
            if (tdiv_reg == 16'h0000) begin
               tdiv_reg               <= `SFPE_ASYNC_DIV;
               SERIAL_TRANSMIT_LINE_O <= tx_reg[0];          // [R13]
               tx_reg <= {1'b1, tx_reg[BW-1:1]};
               tx_bit_reg <= tx_bit_reg + 3'h1;
               // count wraps after data; fill 1 stands a full stop bit
               if (tx_bit_reg == `SFPE_LAST_BIT)
                  tx_stop_reg <= 1'b1;
               if (tx_stop_reg && tx_bit_reg == 3'h1) begin
                  tx_act_reg  <= 1'b0;
                  tx_stop_reg <= 1'b0;
               end
            end else begin
               tdiv_reg <= tdiv_reg - 16'h0001;
            end
         end
      end
   end

   // ************************************************************
   // mode outputs and busy pin
   // ************************************************************
   always @(posedge REF_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         PROG_MODE_O                 <= 1'b0;
         SUB_MODE1_O                 <= 1'b0;
         BUSY_MODE_SELECT_PIN_O      <= 1'b1;
         BUSY_MODE_SELECT_PIN_OE_N_O <= 1'b1;                 // [R4]
      end else begin
         if (state_reg == `SFPE_ST_RESET && entry_s && sclk_s
             && settle_reg == `SFPE_SETTLE_CNT) begin
            PROG_MODE_O <= 1'b1;                              // [R5]
            SUB_MODE1_O <= bmode_s;                           // [R3] [R17]
            BUSY_MODE_SELECT_PIN_OE_N_O <= ~bmode_s;          // [R4] [R9]
         end
         BUSY_MODE_SELECT_PIN_O <=
            !(state_next == `SFPE_ST_IDLE);                   // [R8] [R16]
      end
   end

   // ************************************************************
   // id gate and boot area guard
   // ************************************************************
   always @(posedge REF_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         RX_BYTE_O          <= 8'h00;
         RX_VALID_O         <= 1'b0;
         CMD_ACCEPT_O       <= 1'b0;
         CMD_REJECT_O       <= 1'b0;
         ID_OK_O            <= 1'b0;
         PROG_ERASE_GRANT_O <= 1'b0;
         cmd_wait_reg       <= 1'b1;
         id_run_reg         <= 1'b0;
         id_idx_reg         <= 3'h0;
         id_bad_reg         <= 1'b0;
      end else begin
         RX_VALID_O   <= byte_done;
         CMD_ACCEPT_O <= 1'b0;
         CMD_REJECT_O <= 1'b0;
         PROG_ERASE_GRANT_O <= PROG_ERASE_REQ_I && PROG_MODE_O
                               && !BOOT_AREA_ADDR_I
                               && (ID_OK_O || FLASH_BLANK_I); // [R10]
         if (byte_done) begin
            RX_BYTE_O <= byte_val;
            if (id_run_reg) begin
               // id bytes arrive low byte first
               if (byte_val != ID_CODE[id_idx_reg*8 +: 8])    // [R11]
                  id_bad_reg <= 1'b1;
               if (id_idx_reg == `SFPE_ID_LEN - 3'h1) begin
                  id_run_reg   <= 1'b0;
                  cmd_wait_reg <= 1'b1;
                  ID_OK_O <= !id_bad_reg &&
                     byte_val == ID_CODE[id_idx_reg*8 +: 8];  // [R12]
               end
               id_idx_reg <= id_idx_reg + 3'h1;
            end else if (cmd_wait_reg) begin
               if (byte_val == `SFPE_CMD_ID_CHECK) begin
                  id_run_reg   <= 1'b1;
                  id_idx_reg   <= 3'h0;
                  id_bad_reg   <= 1'b0;
                  cmd_wait_reg <= 1'b0;
                  CMD_ACCEPT_O <= 1'b1;
               end else if (ID_OK_O || FLASH_BLANK_I
                            || byte_val == `SFPE_CMD_STATUS
                            || byte_val == `SFPE_CMD_VERSION) begin
                  CMD_ACCEPT_O <= 1'b1;                       // [R12]
                  cmd_wait_reg <= 1'b0;
               end else begin
                  CMD_REJECT_O <= 1'b1;                       // [R12]
               end
            end
         end
         // the command user ends a command by finishing its work
         if (WORK_DONE_I && !id_run_reg)
            cmd_wait_reg <= 1'b1;
      end
   end
endmodule // sfpe_entry
`default_nettype wire

//--- tb/sfpe_entry_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module sfpe_entry_asserts (
   input wire logic REF_CLK_I,
   input wire logic RESET_N_I,
   input wire logic SERIAL_CLOCK_ENTRY_PIN_I,
   input wire logic FLASH_BLANK_I,
   input wire logic WORK_DONE_I,
   input wire logic BOOT_AREA_ADDR_I,
   input wire logic PROG_ERASE_REQ_I,
   input wire logic BUSY_MODE_SELECT_PIN_O,
   input wire logic BUSY_MODE_SELECT_PIN_OE_N_O,
   input wire logic PROG_MODE_O,
   input wire logic SUB_MODE1_O,
   input wire logic RX_VALID_O,
   input wire logic CMD_ACCEPT_O,
   input wire logic CMD_REJECT_O,
   input wire logic ID_OK_O,
   input wire logic PROG_ERASE_GRANT_O
);
   // ************************************************************
   // port relations
   // ************************************************************
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (!RESET_N_I);
   wire logic drv = ~BUSY_MODE_SELECT_PIN_OE_N_O;
   wire logic bsy = BUSY_MODE_SELECT_PIN_O;
   sequence ready_rise;
      drv && !bsy && $rose(SERIAL_CLOCK_ENTRY_PIN_I);
   endsequence
   // two cycles of driving first, so the entry edge is not mistaken
   sequence in_work;
      drv && !$past(BUSY_MODE_SELECT_PIN_OE_N_O, 2) && bsy && !WORK_DONE_I;
   endsequence
   a_pin_drive_mode:
      assert property (drv |-> PROG_MODE_O && SUB_MODE1_O)
      else $error("busy pin driven outside sync mode");
   a_sub_mode_held:
      assert property (PROG_MODE_O && $past(PROG_MODE_O) |-> $stable(SUB_MODE1_O))
      else $error("sub-mode changed after entry");
   a_boot_grant_refused:
      assert property (PROG_ERASE_GRANT_O |->
         $past(PROG_ERASE_REQ_I) && !$past(BOOT_AREA_ADDR_I))
      else $error("grant without request or for boot area");
   a_cmd_reject_gate:
      assert property (CMD_REJECT_O |-> !FLASH_BLANK_I && !ID_OK_O)
      else $error("command refused while blank or id ok");
   a_cmd_on_byte:
      assert property (CMD_ACCEPT_O || CMD_REJECT_O |->
         RX_VALID_O && !(CMD_ACCEPT_O && CMD_REJECT_O))
      else $error("command verdict without a whole byte");
   a_rx_valid_pulse:
      assert property (RX_VALID_O |=> !RX_VALID_O)
      else $error("byte valid longer than one cycle");
   a_busy_on_rx:
      assert property (ready_rise |-> ##[1:6] bsy)
      else $error("busy not raised when reception began");
   a_busy_held:
      assert property (in_work |=> bsy)
      else $error("busy dropped before work done");
   a_busy_release:
      assert property ($fell(BUSY_MODE_SELECT_PIN_O) && drv && $past(drv)
         |-> $past(WORK_DONE_I))
      else $error("busy fell without work done");
endmodule // sfpe_entry_asserts
bind sfpe_entry sfpe_entry_asserts sfpe_entry_asserts_i (
   .REF_CLK_I(REF_CLK_I), .RESET_N_I(RESET_N_I),
   .SERIAL_CLOCK_ENTRY_PIN_I(SERIAL_CLOCK_ENTRY_PIN_I),
   .FLASH_BLANK_I(FLASH_BLANK_I), .WORK_DONE_I(WORK_DONE_I),
   .BOOT_AREA_ADDR_I(BOOT_AREA_ADDR_I), .PROG_ERASE_REQ_I(PROG_ERASE_REQ_I),
   .BUSY_MODE_SELECT_PIN_O(BUSY_MODE_SELECT_PIN_O),
   .BUSY_MODE_SELECT_PIN_OE_N_O(BUSY_MODE_SELECT_PIN_OE_N_O),
   .PROG_MODE_O(PROG_MODE_O), .SUB_MODE1_O(SUB_MODE1_O),
   .RX_VALID_O(RX_VALID_O), .CMD_ACCEPT_O(CMD_ACCEPT_O),
   .CMD_REJECT_O(CMD_REJECT_O), .ID_OK_O(ID_OK_O),
   .PROG_ERASE_GRANT_O(PROG_ERASE_GRANT_O));
`default_nettype wire

//--- tb/sfpe_prog_model.sv
`timescale 1ns/10ps
`default_nettype none
module sfpe_prog_model (
   output logic       sclk_o,
   output logic       rxd_o,
   input  wire logic  txd_i
);
   // ************************************************************
   // external programmer
   // ************************************************************
   logic [7:0] got;
   initial begin
      sclk_o = 1'b1; // strap high, clock stands high between frames
      rxd_o  = 1'b1;
   end
   // model sources the transfer clock, lsb first
   task automatic send_sync(input logic [7:0] b, input realtime half);
      for (int i = 0; i < 8; i++) begin
         sclk_o = 1'b0;
         rxd_o  = b[i];
         #(half);
         sclk_o = 1'b1;
         got[i] = txd_i;
         #(half);
      end
      rxd_o = ~b[7]; // released line must not show a stale bit
   endtask
   // a uart line idles at mark before a sub-mode 2 reset
   task automatic line_idle();
      rxd_o = 1'b1;
   endtask
   // one sub-mode 2 frame from the device, sampled mid-bit
   task automatic recv_async(output logic [7:0] b, output logic s);
      wait (txd_i === 1'b0);
      #204;
      for (int i = 0; i < 8; i++) begin
         b[i] = txd_i;
         #136;
      end
      s = txd_i;
   endtask
   // start, eight bits lsb first, stop; no clock, no busy
   task automatic send_async(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         rxd_o = f[i];
         #136;
      end
   endtask
endmodule // sfpe_prog_model
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "sfpe_defines.vh"
module testbench;
   localparam logic [55:0] ID = 56'h1A2B_3C4D_5E6F_70; // arbitrary value
   logic       clk, rst_n, entry, bsel, blank, done, load, boot, req;
   logic       idok_e, l_acc, l_rej, s_b;
   logic [7:0] tx_b, l_b, l_t;
   wire        sclk, rxd, bsy, oe_n, txd, prog, sub1, pin;
   wire        rxv, acc, rej, idok, grant;
   wire  [7:0] rx_b;
   int         fail_count = 0;
   int         total_checks = 0;
   int         cyc = 0;
   // shared pin: device level wins while it drives
   assign pin = (oe_n === 1'b0) ? bsy : bsel;
   sfpe_entry #(.ID_CODE(ID), .BW(8)) sfpe_entry_i (
      .REF_CLK_I(clk), .RESET_N_I(rst_n), .MODE_ENTRY_PIN_I(entry),
      .SERIAL_CLOCK_ENTRY_PIN_I(sclk), .BUSY_MODE_SELECT_PIN_I(pin),
      .SERIAL_RECEIVE_LINE_I(rxd), .FLASH_BLANK_I(blank), .WORK_DONE_I(done),
      .TX_LOAD_I(load), .TX_BYTE_I(tx_b), .BOOT_AREA_ADDR_I(boot),
      .PROG_ERASE_REQ_I(req), .BUSY_MODE_SELECT_PIN_O(bsy),
      .BUSY_MODE_SELECT_PIN_OE_N_O(oe_n), .SERIAL_TRANSMIT_LINE_O(txd),
      .PROG_MODE_O(prog), .SUB_MODE1_O(sub1), .RX_BYTE_O(rx_b),
      .RX_VALID_O(rxv), .CMD_ACCEPT_O(acc), .CMD_REJECT_O(rej),
      .ID_OK_O(idok), .PROG_ERASE_GRANT_O(grant));
   sfpe_prog_model sfpe_prog_model_i (.sclk_o(sclk), .rxd_o(rxd), .txd_i(txd));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      if (rxv === 1'b1) begin
         l_b   <= rx_b;
         l_acc <= acc;
         l_rej <= rej;
      end
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         fail_count = fail_count + 1;
         finish_test();
      end
   end
   task automatic check(input string what, input logic [7:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   function automatic logic exp_acc(input logic [7:0] b);
      return blank | idok_e | (b == `SFPE_CMD_ID_CHECK)
         | (b == `SFPE_CMD_STATUS) | (b == `SFPE_CMD_VERSION);
   endfunction
   // id check byte would open an id run; it is sent only as a directed case
   function automatic logic [7:0] rnd_byte();
      logic [7:0] r;
      r = 8'($urandom);
      return (r == `SFPE_CMD_ID_CHECK) ? 8'h00 : r;
   endfunction
   task automatic do_reset(input logic e, bp);
      rst_n = 1'b0;
      entry = e;
      bsel = bp;
      idok_e = 1'b0;
      repeat (20) @(posedge clk);
      #1 rst_n = 1'b1;
      repeat (6) @(posedge clk);
      #1;
   endtask
   task automatic xfer(input logic [7:0] b, input logic chk, fin);
      logic [7:0] t;
      logic       e;
      int         n;
      t = 8'($urandom);
      e = exp_acc(b);
      if (sub1 === 1'b1) begin
         tx_b = t;
         load = 1'b1;
         @(posedge clk);
         #1 load = 1'b0;
         sfpe_prog_model_i.send_sync(b, 62.5); // 125 ns link clock
      end else
         sfpe_prog_model_i.send_async(b);
      repeat (20) @(posedge clk);
      #1;
      check("rx byte", l_b, b);
      if (chk) check("verdict", {l_acc, l_rej}, {e, ~e});
      if (sub1 === 1'b1) begin
         check("tx byte", sfpe_prog_model_i.got, t);
         check("busy", bsy, 1'b1);
      end
      if (fin) begin
         done = 1'b1;
         n = 0;
         while (sub1 === 1'b1 && bsy !== 1'b0 && n < 50) begin
            @(posedge clk);
            #1 n++;
         end
         if (sub1 === 1'b1) check("busy end", bsy, 1'b0);
         @(posedge clk);
         #1 done = 1'b0;
      end
   endtask
   initial begin
      {rst_n, entry, bsel, blank, done, load, boot, req, idok_e} = '0;
      tx_b = 8'h00;
      void'($urandom(51617));
      do_reset(1'b0, 1'b1);
      check("normal", prog, 1'b0);
      do_reset(1'b1, 1'b1);
      check("prog", prog, 1'b1);
      check("sync", sub1, 1'b1);
      check("drive", oe_n, 1'b0);
      check("ready", bsy, 1'b0);
      for (int i = 0; i < 8; i++) begin
         blank = 1'($urandom);
         xfer(rnd_byte(), 1'b1, 1'b1);
      end
      check("sync kept", sub1, 1'b1);
      blank = 1'b0;
      sfpe_prog_model_i.line_idle();
      do_reset(1'b1, 1'b0);
      check("async", sub1, 1'b0);
      check("released", oe_n, 1'b1);
      bsel = 1'b1;
      xfer(8'h41, 1'b1, 1'b1);
      xfer(`SFPE_CMD_STATUS, 1'b1, 1'b1);
      xfer(`SFPE_CMD_VERSION, 1'b1, 1'b1);
      // first pass flips one id bit, second presents the stored code
      for (int k = 0; k < 2; k++) begin
         xfer(`SFPE_CMD_ID_CHECK, 1'b1, 1'b0);
         for (int j = 0; j < 7; j++)
            xfer(ID[8*j +: 8] ^ {7'h00, k == 0 && j == 3}, 1'b0, j == 6);
         idok_e = k[0];
         check("id gate", idok, idok_e);
      end
      for (int i = 0; i < 4; i++) xfer(rnd_byte(), 1'b1, 1'b1);
      check("async kept", sub1, 1'b0);
      tx_b = 8'($urandom);
      load = 1'b1;
      @(posedge clk);
      #1 load = 1'b0;
      sfpe_prog_model_i.recv_async(l_t, s_b);
      check("async tx", l_t, tx_b);
      check("stop bit", s_b, 1'b1);
      req = 1'b1;
      boot = 1'b1;
      repeat (3) @(posedge clk);
      #1 check("boot grant", grant, 1'b0);
      boot = 1'b0;
      repeat (3) @(posedge clk);
      #1 check("user grant", grant, 1'b1);
      finish_test();
   end
endmodule // testbench
`default_nettype wire
